// File: verilog/lrcr_pkg.sv
// package of constants and types for the literal-return and carry-rotate unit
package lrcr_pkg;
    localparam int LRCR_DATA_W = 8;
    localparam int LRCR_ADDR_W = 7;
    localparam int LRCR_PC_W = 15;
    localparam int LRCR_STACK_DEPTH = 16;
    localparam int LRCR_SP_W = 4;
    localparam logic [7:0] LRCR_ACC_RST = 8'h00;
    localparam logic LRCR_CARRY_RST = 1'b0;
    localparam logic [14:0] LRCR_PC_RST = 15'h0000;
    localparam logic [3:0] LRCR_SP_RST = 4'h0;
    localparam int LRCR_RET_CYCLES = 2;
    localparam logic LRCR_DEST_ACC = 1'b0;
    localparam logic LRCR_DEST_FILE = 1'b1;

    // operation selector presented with each instruction
    typedef enum logic [1:0] {
        LRCR_OP_NONE = 2'h0,
        LRCR_OP_RET_LIT = 2'h1,
        LRCR_OP_ROT_LEFT = 2'h2,
        LRCR_OP_ROT_RIGHT = 2'h3
    } lrcr_op_t;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        LRCR_ST_EXEC = 2'b01,
        LRCR_ST_FLUSH = 2'b10
    } lrcr_state_t;
endpackage : lrcr_pkg

// File: verilog/lrcr_rotator.sv
// rotate-through-carry datapath, purely combinational
`timescale 1ns/100ps
module lrcr_rotator #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] operand,
    input wire logic carry_in,
    input wire logic dir_left,
    output logic [WIDTH-1:0] result,
    output logic carry_out
);
    // left takes msb into carry, right takes lsb into carry
    always_comb begin
        if (dir_left) begin
            result = {operand[WIDTH-2:0], carry_in};
            carry_out = operand[WIDTH-1];
        end else begin
            result = {carry_in, operand[WIDTH-1:1]};
            carry_out = operand[0];
        end
    end
endmodule : lrcr_rotator

// File: verilog/lrcr_core.sv
// literal-return and rotate-through-carry execution unit
// Behaviour
// - the literal return writes its 8-bit literal into the accumulator.
// - the literal return loads the program counter from the top of the stack.
// - the literal return takes two instruction cycles before execution resumes.
// - rotate left moves old bit 7 into carry and old carry into bit 0.
// - rotate right moves old bit 0 into carry and old carry into bit 7.
// - destination 0 sends the rotate result to the accumulator, 1 back to the file register.
// - the return pops the stack so the next lower entry becomes the top.
`timescale 1ns/100ps
module lrcr_core
    import lrcr_pkg::*;
#(
    parameter int DATA_W = lrcr_pkg::LRCR_DATA_W,
    parameter int ADDR_W = lrcr_pkg::LRCR_ADDR_W,
    parameter int PC_W = lrcr_pkg::LRCR_PC_W,
    parameter int DEPTH = lrcr_pkg::LRCR_STACK_DEPTH,
    parameter int SP_W = lrcr_pkg::LRCR_SP_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire lrcr_pkg::lrcr_op_t instr_op,
    input wire logic [DATA_W-1:0] instr_literal,
    input wire logic [ADDR_W-1:0] instr_file_addr,
    input wire logic instr_dest,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic push_valid,
    input wire logic [PC_W-1:0] push_addr,
    input wire logic [PC_W-1:0] pc_next_seq,
    output logic instr_ready,
    output logic [DATA_W-1:0] acc,
    output logic carry,
    output logic [PC_W-1:0] pc,
    output logic pc_load,
    output logic file_we,
    output logic [ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic [SP_W-1:0] stack_ptr,
    output logic [PC_W-1:0] top_of_stack_entry
);
    import lrcr_pkg::*;

    logic [DATA_W-1:0] acc_q;
    logic carry_q;
    logic [PC_W-1:0] pc_q;
    logic pc_load_q;
    logic file_we_q;
    logic [ADDR_W-1:0] file_waddr_q;
    logic [DATA_W-1:0] file_wdata_q;
    logic [SP_W-1:0] sp_q;
    logic [PC_W-1:0] stack_mem [DEPTH];
    lrcr_state_t state_q;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;
    logic go;
    logic do_ret;
    logic do_rot;
    logic [SP_W-1:0] sp_dec;

    assign instr_ready = (state_q == LRCR_ST_EXEC);
    assign go = instr_valid && instr_ready;
    assign do_ret = go && (instr_op == LRCR_OP_RET_LIT);
    assign do_rot = go && ((instr_op == LRCR_OP_ROT_LEFT) || (instr_op == LRCR_OP_ROT_RIGHT));
    assign sp_dec = sp_q - SP_W'(1);

    // shared rotate datapath
    lrcr_rotator #(
        .WIDTH(DATA_W)
    ) u_rot (
        .operand(file_rdata),
        .carry_in(carry_q),
        .dir_left(instr_op == LRCR_OP_ROT_LEFT),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // two-cycle sequencer: second cycle flushes the prefetched word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= LRCR_ST_EXEC;
        end else begin
            case (state_q)
                LRCR_ST_EXEC: begin
                    if (do_ret) begin
                        state_q <= LRCR_ST_FLUSH;
                    end
                end
                LRCR_ST_FLUSH: begin
                    state_q <= LRCR_ST_EXEC;
                end
                default: begin
                    state_q <= LRCR_ST_EXEC;
                end
            endcase
        end
    end

    // accumulator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_q <= LRCR_ACC_RST;
        end else if (do_ret) begin
            acc_q <= instr_literal;
        end else if (do_rot && instr_dest == LRCR_DEST_ACC) begin
            acc_q <= rot_result;
        end
    end

    // carry flag, touched by rotates only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carry_q <= LRCR_CARRY_RST;
        end else if (do_rot) begin
            carry_q <= rot_carry;
        end
    end

    // file write-back port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            file_we_q <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= '0;
        end else begin
            file_we_q <= do_rot && (instr_dest == LRCR_DEST_FILE);
            if (do_rot) begin
                file_waddr_q <= instr_file_addr;
                file_wdata_q <= rot_result;
            end
        end
    end

    // program counter: return address on return, sequential on other accepted instructions
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_q <= LRCR_PC_RST;
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= do_ret;
            if (do_ret) begin
                pc_q <= stack_mem[sp_dec];
            end else if (go) begin
                pc_q <= pc_next_seq;
            end
        end
    end

    // stack pointer; a pop wins over a same-cycle push
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sp_q <= LRCR_SP_RST;
        end else if (do_ret) begin
            sp_q <= sp_dec;
        end else if (push_valid) begin
            sp_q <= sp_q + SP_W'(1);
        end
    end

    // stack storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push_valid && !do_ret) begin
            stack_mem[sp_q] <= push_addr;
        end
    end

    assign acc = acc_q;
    assign carry = carry_q;
    assign pc = pc_q;
    assign pc_load = pc_load_q;
    assign file_we = file_we_q;
    assign file_waddr = file_waddr_q;
    assign file_wdata = file_wdata_q;
    assign stack_ptr = sp_q;
    assign top_of_stack_entry = stack_mem[sp_dec];

    // assertions
    ret_literal_a: assert property (@(posedge core_clk) disable iff (rst)
        do_ret |=> acc_q == $past(instr_literal))
        else $error("literal not loaded into accumulator");

    ret_pc_a: assert property (@(posedge core_clk) disable iff (rst)
        do_ret |=> pc_q == $past(top_of_stack_entry) && pc_load_q)
        else $error("pc not loaded from stack top");

    ret_two_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
        do_ret |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");

    rot_left_a: assert property (@(posedge core_clk) disable iff (rst)
        do_rot && instr_op == LRCR_OP_ROT_LEFT |=>
        carry_q == $past(file_rdata[DATA_W-1]))
        else $error("left rotate carry wrong");

    rot_right_a: assert property (@(posedge core_clk) disable iff (rst)
        do_rot && instr_op == LRCR_OP_ROT_RIGHT |=>
        carry_q == $past(file_rdata[0]))
        else $error("right rotate carry wrong");

    rot_dest_a: assert property (@(posedge core_clk) disable iff (rst)
        do_rot && instr_dest == LRCR_DEST_ACC |=> !file_we_q && acc_q == $past(rot_result))
        else $error("accumulator destination wrong");

    stack_pop_a: assert property (@(posedge core_clk) disable iff (rst)
        do_ret |=> sp_q == $past(sp_q) - SP_W'(1))
        else $error("stack not popped");

    ret_flags_a: assert property (@(posedge core_clk) disable iff (rst)
        !do_rot |=> $stable(carry_q))
        else $error("carry changed outside rotate");

    rot_file_a: assert property (@(posedge core_clk) disable iff (rst)
        do_rot && instr_dest == LRCR_DEST_FILE |=>
        file_we_q && file_wdata_q == $past(rot_result) && acc_q == $past(acc_q))
        else $error("file destination wrong");

    ret_carry_a: assert property (@(posedge core_clk) disable iff (rst)
        do_ret |=> carry_q == $past(carry_q))
        else $error("return changed carry");

    // the pc load strobe must drop after one cycle
    ret_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        pc_load_q |=> !pc_load_q)
        else $error("pc load pulse too long");
endmodule : lrcr_core

// File: dv/lrcr_core_test.sv
// self-checking bench for the literal-return and carry-rotate unit
`timescale 1ns/100ps
module lrcr_core_test;
    import lrcr_pkg::*;
    typedef struct {lrcr_op_t op; logic d; logic [7:0] f; logic [7:0] res; logic c;} lrcr_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    lrcr_op_t instr_op = LRCR_OP_NONE;
    logic [7:0] instr_literal = 8'h00;
    logic [6:0] instr_file_addr = 7'h00;
    logic instr_dest = 1'b0;
    logic [7:0] file_rdata = 8'h00;
    logic push_valid = 1'b0;
    logic [14:0] push_addr = 15'h0000;
    logic [14:0] pc_next_seq = 15'h1234;
    logic instr_ready, carry, pc_load, file_we;
    logic [7:0] acc, file_wdata, exp_acc;
    logic [14:0] pc, top_of_stack_entry;
    logic [6:0] file_waddr;
    logic [3:0] stack_ptr;
    int fails = 0;
    int checked = 0;
    // rotate cases in order, carry chains from one row to the next
    lrcr_row_t rows [6] = '{
        '{LRCR_OP_ROT_LEFT, 1'b0, 8'hE6, 8'hCC, 1'b1}, '{LRCR_OP_ROT_LEFT, 1'b1, 8'h80, 8'h01, 1'b1},
        '{LRCR_OP_ROT_RIGHT, 1'b0, 8'h01, 8'h80, 1'b1}, '{LRCR_OP_ROT_RIGHT, 1'b1, 8'hFE, 8'hFF, 1'b0},
        '{LRCR_OP_ROT_LEFT, 1'b0, 8'h7F, 8'hFE, 1'b0}, '{LRCR_OP_ROT_RIGHT, 1'b0, 8'h00, 8'h00, 1'b0}};

    lrcr_core DUT (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_literal(instr_literal), .instr_file_addr(instr_file_addr), .instr_dest(instr_dest),
        .file_rdata(file_rdata), .push_valid(push_valid), .push_addr(push_addr), .pc_next_seq(pc_next_seq),
        .instr_ready(instr_ready), .acc(acc), .carry(carry), .pc(pc), .pc_load(pc_load), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .stack_ptr(stack_ptr),
        .top_of_stack_entry(top_of_stack_entry));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // compare one value and count it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // present an instruction and wait one clock edge, whether or not it is taken
    task automatic issue(input lrcr_op_t op, input logic d, input logic [7:0] lit, input logic [7:0] f);
        instr_valid = 1'b1;
        instr_op = op;
        instr_dest = d;
        instr_literal = lit;
        file_rdata = f;
        @(posedge core_clk);
        #1;
    endtask : issue

    // print counts and verdict, then stop
    task automatic close_out();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // watchdog well beyond the expected run of about 40 cycles
    initial begin
        #20000;
        fails++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        chk(acc, 16'h0000);
        chk(carry, 16'h0000);
        chk(pc, 16'h0000);
        chk(stack_ptr, 16'h0000);
        chk(instr_ready, 16'h0001);
        chk(pc_load, 16'h0000);
        chk(file_we, 16'h0000);
        rst = 1'b0;
        $display("test reset done");
        @(posedge core_clk);
        #1;
        exp_acc = 8'h00;
        // back-to-back rotates from the table
        foreach (rows[i]) begin
            instr_file_addr = 7'h10 + 7'(i);
            issue(rows[i].op, rows[i].d, 8'h00, rows[i].f);
            if (!rows[i].d) exp_acc = rows[i].res;
            chk(carry, rows[i].c);
            chk(acc, exp_acc);
            chk(file_we, rows[i].d);
            if (rows[i].d) chk(file_wdata, rows[i].res);
            if (rows[i].d) chk(file_waddr, 7'h10 + 7'(i));
            chk(pc, pc_next_seq);
        end
        instr_valid = 1'b0;
        $display("test rotate table done");
        // fill three stack entries
        for (int k = 1; k <= 3; k++) begin
            push_valid = 1'b1;
            push_addr = 15'(k * 256);
            @(posedge core_clk);
            #1;
        end
        push_valid = 1'b0;
        chk(stack_ptr, 16'h0003);
        chk(top_of_stack_entry, 16'h0300);
        // literal return, then a refused rotate in the dead cycle
        issue(LRCR_OP_RET_LIT, 1'b0, 8'hA5, 8'hFF);
        chk(acc, 16'h00A5);
        chk(pc, 16'h0300);
        chk(pc_load, 16'h0001);
        chk(instr_ready, 16'h0000);
        chk(stack_ptr, 16'h0002);
        chk(top_of_stack_entry, 16'h0200);
        chk(carry, 16'h0000);
        issue(LRCR_OP_ROT_LEFT, 1'b0, 8'h00, 8'hFF);
        chk(acc, 16'h00A5);
        chk(carry, 16'h0000);
        chk(pc_load, 16'h0000);
        chk(instr_ready, 16'h0001);
        // second return right after the dead cycle pops the next entry
        issue(LRCR_OP_RET_LIT, 1'b0, 8'h3C, 8'h00);
        chk(acc, 16'h003C);
        chk(pc, 16'h0200);
        chk(stack_ptr, 16'h0001);
        issue(LRCR_OP_NONE, 1'b0, 8'h00, 8'h00);
        issue(LRCR_OP_NONE, 1'b0, 8'h00, 8'h00);
        chk(pc, pc_next_seq);
        chk(acc, 16'h003C);
        instr_valid = 1'b0;
        $display("test return done");
        @(posedge core_clk);
        #1;
        // a push in the same cycle as a return is dropped
        push_valid = 1'b1;
        push_addr = 15'h0777;
        issue(LRCR_OP_RET_LIT, 1'b0, 8'h5A, 8'h00);
        push_valid = 1'b0;
        chk(stack_ptr, 16'h0000);
        chk(pc, 16'h0100);
        chk(acc, 16'h005A);
        // reset in the dead cycle, then an instruction at the first edge after release
        rst = 1'b1;
        instr_valid = 1'b0;
        @(posedge core_clk);
        #1;
        chk(instr_ready, 16'h0001);
        chk(pc_load, 16'h0000);
        chk(stack_ptr, 16'h0000);
        chk(acc, 16'h0000);
        chk(pc, 16'h0000);
        rst = 1'b0;
        issue(LRCR_OP_ROT_LEFT, 1'b1, 8'h00, 8'h81);
        chk(carry, 16'h0001);
        chk(file_wdata, 16'h0002);
        chk(file_we, 16'h0001);
        chk(acc, 16'h0000);
        instr_valid = 1'b0;
        $display("test reset and push clash done");
        close_out();
    end
endmodule : lrcr_core_test
